// ==== include/pport_pkg.sv ====
// constants and types shared by the parallel data port
package pport_pkg;
    // ******************************
    // widths
    // ******************************
    localparam int RESULT_W = 12;
    localparam int CHAN_W = 3;
    localparam int LOW_W = 8;
    localparam int UPPER_W = 3;
    localparam int SYNC_STAGES = 2;
    // ******************************
    // field positions
    // ******************************
    localparam int BIT8_POS = 8;
    localparam int UPPER_LSB = 9;
    localparam int HB_DATA_W = 4;
    localparam int HB_CHAN_LSB = 4;
    localparam int HB_PAD_BIT = 7;
    localparam int TEN_BIT_PAD = 2;
    localparam int TEN_BIT_RESULT = 10;
    // ******************************
    // reset values
    // ******************************
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
    localparam logic [LOW_W-1:0] LOW_RST = 8'h00;
    localparam logic [UPPER_W-1:0] UPPER_RST = 3'h0;
    localparam logic [SYNC_STAGES-1:0] STROBE_IDLE = 2'h3;
    localparam logic [SYNC_STAGES-1:0] LEVEL_LOW = 2'h0;
    // ******************************
    // types
    // ******************************
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} bus_state_t;
endpackage

// ==== include/result_stream_if.sv ====
// stream of conversion results with channel identifier
`timescale 1ns/1ps
interface result_stream_if #(parameter int DATA_W = pport_pkg::RESULT_W);
    logic valid;
    logic ready;
    logic [DATA_W-1:0] data;
    logic [pport_pkg::CHAN_W-1:0] chan;
    modport producer (output valid, output data, output chan, input ready);
    modport consumer (input valid, input data, input chan, output ready);
endinterface

// ==== src/adc_parallel_data_port.sv ====
// parallel host data port: result reads and register writes
// Operation
// RULE_01: low eight data lines are three-state, read results, accept writes, strobe gated.
// RULE_02: ten-bit variant reads two lowest lines as zero, lsb on line two.
// RULE_03: word mode high: shared pin is data bit eight, three-state, strobe gated.
// RULE_04: word mode low: shared pin is an upper byte select input.
// RULE_05: byte mode, select low: low byte on the eight low lines.
// RULE_06: byte mode, select high: top four bits on lines zero to three.
// RULE_07: upper byte read carries the result's channel id on bits four to six.
// RULE_08: host writes zeros on bits four to seven of an upper byte.
// RULE_09: ten-bit low byte read: two low bits zero, six data bits above.
// RULE_10: result driven after read strobe falls while chip select is low.
// RULE_11: host asserts write strobe with chip select to load registers.
// RULE_12: lines float whenever chip select is high or no read runs.
`timescale 1ns/1ps
module adc_parallel_data_port
    import pport_pkg::*;
#(
    parameter int RESULT_BITS = RESULT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic word_mode,
    input wire logic [pport_pkg::LOW_W-1:0] low_data_lines_i,
    output logic [pport_pkg::LOW_W-1:0] low_data_lines_o,
    output logic low_data_lines_oe,
    input wire logic bit8_or_upper_byte_select_i,
    output logic bit8_or_upper_byte_select_o,
    output logic bit8_or_upper_byte_select_oe,
    input wire logic [pport_pkg::UPPER_W-1:0] upper_data_lines_i,
    output logic [pport_pkg::UPPER_W-1:0] upper_data_lines_o,
    output logic upper_data_lines_oe,
    input wire logic res_valid,
    input wire logic [pport_pkg::RESULT_W-1:0] res_data,
    input wire logic [pport_pkg::CHAN_W-1:0] res_chan,
    output logic res_ready,
    output logic reg_wr_valid,
    output logic [pport_pkg::RESULT_W-1:0] reg_wr_word
);
    import pport_pkg::*;

    if (RESULT_BITS != RESULT_W && RESULT_BITS != TEN_BIT_RESULT) begin : g_bad_bits
        $error("RESULT_BITS must be 12 or 10");
    end

    // ******************************
    // pin synchronisers
    // ******************************
    logic [SYNC_STAGES-1:0] cs_n_q;
    logic [SYNC_STAGES-1:0] rd_n_q;
    logic [SYNC_STAGES-1:0] wr_n_q;
    logic [SYNC_STAGES-1:0] wm_q;
    logic [SYNC_STAGES-1:0] b8_q;
    logic [LOW_W-1:0] low_m_q;
    logic [LOW_W-1:0] low_s_q;
    logic [UPPER_W-1:0] up_m_q;
    logic [UPPER_W-1:0] up_s_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_n_q <= STROBE_IDLE;
            rd_n_q <= STROBE_IDLE;
            wr_n_q <= STROBE_IDLE;
            wm_q <= LEVEL_LOW;
            b8_q <= LEVEL_LOW;
        end else begin
            cs_n_q <= {cs_n_q[0], cs_n};
            rd_n_q <= {rd_n_q[0], rd_n};
            wr_n_q <= {wr_n_q[0], wr_n};
            wm_q <= {wm_q[0], word_mode};
            b8_q <= {b8_q[0], bit8_or_upper_byte_select_i};
        end
    end

    always_ff @(posedge sys_clk) begin
        low_m_q <= low_data_lines_i;
        low_s_q <= low_m_q;
        up_m_q <= upper_data_lines_i;
        up_s_q <= up_m_q;
    end

    wire cs_s = ~cs_n_q[1];
    wire rd_act = cs_s & ~rd_n_q[1];
    wire wr_act = cs_s & ~wr_n_q[1]; // RULE_11
    wire wm_s = wm_q[1];
    // in byte mode the shared pin is an input select, never data
    wire hb_s = ~wm_s & b8_q[1]; // RULE_04

    // ******************************
    // result buffer and held result
    // ******************************
    result_stream_if #(.DATA_W(RESULT_W)) in_s ();
    result_stream_if #(.DATA_W(RESULT_W)) out_s ();

    assign in_s.valid = res_valid;
    assign in_s.data = res_data;
    assign in_s.chan = res_chan;
    assign res_ready = in_s.ready;

    result_buffer #(.DATA_W(RESULT_W)) u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_s(in_s),
        .out_s(out_s)
    );

    bus_state_t state_q;
    bus_state_t state_d;
    logic [RESULT_W-1:0] cur_q;
    logic [CHAN_W-1:0] cur_chan_q;
    logic cur_valid_q;
    logic hb_q;
    logic wm_rd_q;

    wire load_cur = out_s.valid & out_s.ready;
    assign out_s.ready = ~cur_valid_q & (state_q != ST_READ);

    // a word is consumed once its last part has been read out
    wire read_done = (state_q == ST_READ) & ~rd_act;
    wire consume = read_done & (wm_rd_q | hb_q);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_q <= RESULT_RST;
            cur_chan_q <= CHAN_RST;
            cur_valid_q <= 1'b0;
        end else if (load_cur) begin
            cur_q <= out_s.data;
            cur_chan_q <= out_s.chan;
            cur_valid_q <= 1'b1;
        end else if (consume) begin
            cur_valid_q <= 1'b0;
        end
    end

    // ******************************
    // read data formatting
    // ******************************
    wire [RESULT_W-1:0] word_al = (RESULT_BITS == TEN_BIT_RESULT)
        ? {cur_q[TEN_BIT_RESULT-1:0], {TEN_BIT_PAD{1'b0}}} // RULE_02 RULE_09
        : cur_q;
    wire [LOW_W-1:0] hi_byte = {1'b0, cur_chan_q, // RULE_07
        word_al[RESULT_W-1 -: HB_DATA_W]}; // RULE_06
    wire [LOW_W-1:0] byte_sel = hb_s ? hi_byte : word_al[LOW_W-1:0]; // RULE_05
    wire [LOW_W-1:0] low_d = wm_s ? word_al[LOW_W-1:0] : byte_sel; // RULE_01
    wire b8_d = word_al[BIT8_POS]; // RULE_03
    wire [UPPER_W-1:0] up_d = word_al[RESULT_W-1:UPPER_LSB];

    // ******************************
    // bus sequencer
    // ******************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (rd_act) begin
                    state_d = ST_READ; // RULE_10
                end else if (wr_act) begin
                    state_d = ST_WRITE;
                end
            end
            ST_READ: begin
                if (!rd_act) begin
                    state_d = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (!wr_act) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    wire drive_d = (state_d == ST_READ); // RULE_12

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            hb_q <= 1'b0;
            wm_rd_q <= 1'b0;
            low_data_lines_oe <= 1'b0;
            bit8_or_upper_byte_select_oe <= 1'b0;
            upper_data_lines_oe <= 1'b0;
            low_data_lines_o <= LOW_RST;
            bit8_or_upper_byte_select_o <= 1'b0;
            upper_data_lines_o <= UPPER_RST;
        end else begin
            state_q <= state_d;
            hb_q <= hb_s;
            wm_rd_q <= wm_s;
            low_data_lines_oe <= drive_d; // RULE_01
            bit8_or_upper_byte_select_oe <= drive_d & wm_s; // RULE_03 RULE_04
            upper_data_lines_oe <= drive_d & wm_s;
            low_data_lines_o <= low_d;
            bit8_or_upper_byte_select_o <= b8_d;
            upper_data_lines_o <= up_d;
        end
    end

    // ******************************
    // register writes
    // ******************************
    logic [RESULT_W-1:0] wr_word_q;
    logic [LOW_W-1:0] wr_low_q;
    logic wr_hb_q;
    logic wr_wm_q;

    wire write_done = (state_q == ST_WRITE) & ~wr_act;
    // upper byte bits above the data nibble are zero by host contract
    wire [RESULT_W-1:0] byte_word = {low_s_q[HB_DATA_W-1:0], wr_low_q}; // RULE_06 RULE_08
    wire [RESULT_W-1:0] full_word = {up_s_q, b8_q[1], low_s_q};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_word_q <= RESULT_RST;
            wr_low_q <= LOW_RST;
            wr_hb_q <= 1'b0;
            wr_wm_q <= 1'b0;
        end else if (state_q == ST_WRITE && wr_act) begin
            wr_hb_q <= hb_s;
            wr_wm_q <= wm_s;
            wr_word_q <= wm_s ? full_word : byte_word;
            if (!wm_s && !hb_s) begin
                wr_low_q <= low_s_q; // RULE_05
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_wr_valid <= 1'b0;
            reg_wr_word <= RESULT_RST;
        end else begin
            reg_wr_valid <= write_done & (wr_wm_q | wr_hb_q); // RULE_11
            if (write_done) begin
                reg_wr_word <= wr_word_q;
            end
        end
    end
endmodule

// ==== src/result_buffer.sv ====
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module result_buffer
    import pport_pkg::*;
#(
    parameter int DATA_W = RESULT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    result_stream_if.consumer in_s,
    result_stream_if.producer out_s
);
    import pport_pkg::*;

    // ******************************
    // storage
    // ******************************
    logic [DATA_W-1:0] data_q [2];
    logic [CHAN_W-1:0] chan_q [2];
    logic wptr_q;
    logic rptr_q;
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic in_ready_q;

    wire push = in_s.valid & in_ready_q;
    wire pop = out_s.valid & out_s.ready;

    assign count_d = count_q + {1'b0, push} - {1'b0, pop};
    assign in_s.ready = in_ready_q;
    assign out_s.valid = (count_q != 2'h0);
    assign out_s.data = data_q[rptr_q];
    assign out_s.chan = chan_q[rptr_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            data_q[wptr_q] <= in_s.data;
            chan_q[wptr_q] <= in_s.chan;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            count_q <= 2'h0;
            in_ready_q <= 1'b0;
        end else begin
            wptr_q <= wptr_q ^ push;
            rptr_q <= rptr_q ^ pop;
            count_q <= count_d;
            in_ready_q <= (count_d != 2'h2);
        end
    end
endmodule

// ==== test/host_bus_model.sv ====
// host bus model: strobes and the shared data lines
`timescale 1ns/1ps
module host_bus_model (
    input wire logic sys_clk,
    input wire logic word_mode,
    output logic cs_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic wr_n = 1'b1,
    input wire logic [7:0] low_data_lines_o,
    input wire logic low_data_lines_oe,
    input wire logic bit8_or_upper_byte_select_o,
    input wire logic bit8_or_upper_byte_select_oe,
    input wire logic [2:0] upper_data_lines_o,
    input wire logic upper_data_lines_oe,
    output logic [7:0] low_data_lines_i,
    output logic bit8_or_upper_byte_select_i,
    output logic [2:0] upper_data_lines_i
);
    logic [11:0] h_d = 12'h000;
    logic h_oe = 1'b0;
    logic sel = 1'b0;
    // released lines show the inverse of the last value
    assign low_data_lines_i = low_data_lines_oe ? low_data_lines_o : h_oe ? h_d[7:0] : ~h_d[7:0];
    assign bit8_or_upper_byte_select_i = bit8_or_upper_byte_select_oe ?
        bit8_or_upper_byte_select_o : !word_mode ? sel : h_oe ? h_d[8] : ~h_d[8];
    assign upper_data_lines_i = upper_data_lines_oe ? upper_data_lines_o :
        h_oe ? h_d[11:9] : ~h_d[11:9];
    task automatic xfer(input logic wr, input logic hi, input logic [11:0] d);
        @(posedge sys_clk);
        sel <= hi;
        h_d <= d;
        h_oe <= wr;
        cs_n <= 1'b0;
        rd_n <= wr;
        wr_n <= !wr;
        repeat (8) @(posedge sys_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        h_oe <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// ==== test/pport_sva.sv ====
// assertions on the parallel data port pins
`timescale 1ns/1ps
module pport_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic word_mode,
    input wire logic low_data_lines_oe,
    input wire logic bit8_or_upper_byte_select_oe,
    input wire logic upper_data_lines_oe,
    input wire logic reg_wr_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_cs_idle; cs_n [*5] |-> !low_data_lines_oe; endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("bus driven while deselected");
    property p_rd_idle; rd_n [*5] |-> !low_data_lines_oe && !upper_data_lines_oe; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("bus driven with no read");
    property p_rd_drive; (!cs_n && !rd_n) [*5] |-> low_data_lines_oe; endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read not answered");
    property p_rd_cause; $rose(low_data_lines_oe) |-> !$past(cs_n, 3) && !$past(rd_n, 3);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("drive without read");
    property p_byte;
        !word_mode [*5] |-> !bit8_or_upper_byte_select_oe && !upper_data_lines_oe;
    endproperty
    a_byte: assert property (p_byte) else $error("shared pin driven in byte mode");
    property p_word; word_mode [*5] |-> bit8_or_upper_byte_select_oe == low_data_lines_oe;
    endproperty
    a_word: assert property (p_word) else $error("bit eight not driven with word");
    property p_wr_once; reg_wr_valid |=> !reg_wr_valid; endproperty
    a_wr_once: assert property (p_wr_once) else $error("write pulse too long");
    property p_wr_cause; $rose(reg_wr_valid) |-> $past(wr_n) && !$past(wr_n, 5); endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("write pulse without strobe");
endmodule
bind adc_parallel_data_port pport_sva chk (.sys_clk, .rst, .cs_n, .rd_n, .wr_n, .word_mode,
    .low_data_lines_oe, .bit8_or_upper_byte_select_oe, .upper_data_lines_oe, .reg_wr_valid);

// ==== test/tb.sv ====
// self-checking bench of the parallel data port
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic word_mode = 1'b1;
    logic res_valid = 1'b0;
    logic [11:0] res_data = 12'h000;
    logic [2:0] res_chan = 3'h0;
    logic cs_n, rd_n, wr_n, low_data_lines_oe, bit8_or_upper_byte_select_i;
    logic bit8_or_upper_byte_select_o, bit8_or_upper_byte_select_oe, upper_data_lines_oe;
    logic res_ready, reg_wr_valid, oe_q = 1'b0;
    logic [7:0] low_data_lines_i, low_data_lines_o;
    logic [2:0] upper_data_lines_i, upper_data_lines_o;
    logic [11:0] reg_wr_word;
    logic [7:0] ten_low_o;
    logic ten_b8_o;
    logic [2:0] ten_up_o;
    logic [11:0] tq[$];
    logic [11:0] t;
    logic [13:0] eq[$];
    logic [11:0] ew[$];
    logic [14:0] rq[$];
    logic [14:0] held = 15'h0000;
    logic [13:0] e;
    int n_errors = 0, check_count = 0, cyc = 0;
    integer seed = 32'he1e51469;
    adc_parallel_data_port DUT (.sys_clk, .rst, .cs_n, .rd_n, .wr_n, .word_mode,
        .low_data_lines_i, .low_data_lines_o, .low_data_lines_oe, .bit8_or_upper_byte_select_i,
        .bit8_or_upper_byte_select_o, .bit8_or_upper_byte_select_oe, .upper_data_lines_i,
        .upper_data_lines_o, .upper_data_lines_oe, .res_valid, .res_data, .res_chan,
        .res_ready, .reg_wr_valid, .reg_wr_word);
    // ten-bit variant on the same pins, watched for its read data only
    adc_parallel_data_port #(.RESULT_BITS(pport_pkg::TEN_BIT_RESULT)) dut_ten (.sys_clk, .rst,
        .cs_n, .rd_n, .wr_n, .word_mode, .low_data_lines_i, .low_data_lines_o(ten_low_o),
        .low_data_lines_oe(), .bit8_or_upper_byte_select_i,
        .bit8_or_upper_byte_select_o(ten_b8_o), .bit8_or_upper_byte_select_oe(),
        .upper_data_lines_i, .upper_data_lines_o(ten_up_o), .upper_data_lines_oe(),
        .res_valid, .res_data, .res_chan, .res_ready(), .reg_wr_valid(), .reg_wr_word());
    host_bus_model host (.sys_clk, .word_mode, .cs_n, .rd_n, .wr_n, .low_data_lines_o,
        .low_data_lines_oe, .bit8_or_upper_byte_select_o, .bit8_or_upper_byte_select_oe,
        .upper_data_lines_o, .upper_data_lines_oe, .low_data_lines_i,
        .bit8_or_upper_byte_select_i, .upper_data_lines_i);
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp_read(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_write(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t write %h expected %h", $time, got, exp);
        end
    endtask
    task automatic offer(input logic [11:0] d, input logic [2:0] c);
        rq.push_back({c, d});
        @(posedge sys_clk);
        res_valid <= 1'b1;
        res_data <= d;
        res_chan <= c;
        do @(posedge sys_clk); while (res_ready !== 1'b1);
        res_valid <= 1'b0;
        res_data <= 12'($random(seed));
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [1:0] kind);
        if (rq.size() > 0) held = rq[0];
        if (kind == 2'h0) eq.push_back({kind, held[11:0]});
        if (kind == 2'h1) eq.push_back({kind, 4'h0, held[7:0]});
        if (kind == 2'h2) eq.push_back({kind, 5'h00, held[14:12], held[11:8]});
        if (kind == 2'h0) tq.push_back({held[9:0], 2'h0});
        if (kind == 2'h1) tq.push_back({4'h0, held[5:0], 2'h0});
        if (kind == 2'h2) tq.push_back({5'h00, held[14:12], held[9:6]});
        if (kind != 2'h1 && rq.size() > 0) void'(rq.pop_front());
        host.xfer(1'b0, kind[1], 12'h000);
    endtask
    task automatic wr(input logic [11:0] d);
        ew.push_back(d);
        if (word_mode) host.xfer(1'b1, 1'b0, d);
        else begin
            host.xfer(1'b1, 1'b0, {4'h0, d[7:0]});
            host.xfer(1'b1, 1'b1, {8'h00, d[11:8]});
        end
    endtask
    always @(posedge sys_clk) begin
        oe_q <= low_data_lines_oe;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
        if (low_data_lines_oe === 1'b1 && oe_q !== 1'b1) begin
            e = (eq.size() > 0) ? eq.pop_front() : 14'h0fff;
            if (e[13:12] == 2'h0) cmp_read({upper_data_lines_o, bit8_or_upper_byte_select_o,
                low_data_lines_o}, e[11:0]);
            if (e[13:12] == 2'h1) cmp_read({4'h0, low_data_lines_o}, e[11:0]);
            if (e[13:12] == 2'h2) cmp_read({4'h0, low_data_lines_o}, e[11:0]);
            t = (e[13:12] == 2'h0) ? {ten_up_o, ten_b8_o, ten_low_o} : {4'h0, ten_low_o};
            cmp_read(t, (tq.size() > 0) ? tq.pop_front() : ~t);
        end
        if (reg_wr_valid === 1'b1)
            cmp_write(reg_wr_word, ew.size() > 0 ? ew.pop_front() : ~reg_wr_word);
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 12; i++) begin
            if (i == 6) begin
                word_mode <= 1'b0;
                repeat (4) @(posedge sys_clk);
            end
            offer(12'($random(seed)), 3'($random(seed)));
            if (word_mode) rd(2'h0);
            else begin
                rd(2'h1);
                rd(2'h2);
            end
            wr(12'($random(seed)));
        end
        rd(2'h1);
        rd(2'h2);
        word_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        repeat (3) offer(12'($random(seed)), 3'($random(seed)));
        fork
            offer(12'($random(seed)), 3'($random(seed)));
        join_none
        repeat (4) rd(2'h0);
        repeat (20) @(posedge sys_clk);
        summarize();
    end
endmodule
